// ---- common/dso_defs.vh ----
// constants for the deserializer output and lock control block
`ifndef DSO_DEFS_VH
`define DSO_DEFS_VH
// ==========================================================
// serial frame layout (one sample per clock)
`define DSO_FRAME_LEN 4'd12
`define DSO_FRAME_LAST 4'd11
`define DSO_HALF_FRAME 4'd6
`define DSO_START_POS 4'd0
`define DSO_DATA_FIRST 4'd1
`define DSO_STOP_POS 4'd11
`define DSO_START_BIT 1'b1
`define DSO_STOP_BIT 1'b0
// ==========================================================
// lock and reference defaults
`define DSO_LOCK_FRAMES 8'd4
`define DSO_REF_TIMEOUT_NS 640
`define DSO_CLK_PERIOD_NS 10
// ==========================================================
// register map (byte addresses)
`define DSO_REG_CTRL 4'h0
`define DSO_REG_STATUS 4'h4
`define DSO_REG_COUNT 4'h8
`define DSO_CTRL_RESYNC 0
`define DSO_ST_LOCKED 0
`define DSO_ST_SLEEP 1
`define DSO_ST_DRIVE 2
`define DSO_ST_OVERFLOW 3
`define DSO_ST_LEVEL_LO 4
`define DSO_ST_LEVEL_HI 5
`endif

// ---- verilog/dso_deserializer_out.v ----
// deserializer output, lock and drive control with apb status port
`timescale 1ns/1ps
`include "dso_defs.vh"

// Function
// - a recovered clock at the word rate, divided down from the system clock, strobes the ten-bit word.
// - edge select high makes the word valid at the rising recovered-clock edge, low at the falling one.
// - the active-low lock output goes low once locked to the embedded clock edge and stays high while unlocked.
// - powerdown low stops lock tracking, sleeps, and floats word, recovered clock and lock whatever the enable.
// - powerdown high with output enable low floats word and recovered clock while lock still reports.
// - powerdown and output enable high make the lock output follow the lock state.
// - while the lock output is high the word and recovered clock stay floating.
// - the recovered clock runs only while locked, and word and clock are driven when awake, enabled and locked.
module dso_deserializer_out #(
    parameter LOCK_FRAMES = `DSO_LOCK_FRAMES,
    parameter WORD_W = 10
) (
    input wire clock,                       // 100 MHz system clock
    input wire sys_rst,                     // async reset, active high
    input wire serial_in_positive,          // serial line, true side
    input wire serial_in_negative,          // serial line, inverted side
    input wire pll_reference_clock,         // reference, sampled level
    input wire recovered_clock_edge_select, // 1 rising, 0 falling
    input wire sleep_request_n,             // powerdown, active low
    input wire output_enable,               // word/clock enable, high
    input wire out_ready,                   // downstream ready, high
    output reg [WORD_W-1:0] parallel_word_out, // word pin output value
    output reg parallel_word_oe_n,          // 0 while word is driven
    output reg recovered_clock,             // recovered clock value
    output reg recovered_clock_oe_n,        // 0 while clock is driven
    output reg lock_n,                      // lock, active low
    output reg lock_oe_n,                   // 0 while lock is driven
    input wire psel,                        // apb select
    input wire penable,                     // apb enable
    input wire pwrite,                      // apb direction
    input wire [3:0] paddr,                 // apb byte address
    input wire [31:0] pwdata,               // apb write data
    output reg [31:0] prdata,               // apb read data
    output reg pready,                      // apb ready
    output reg pslverr                      // apb error
);
    localparam REF_CYCLES = `DSO_REF_TIMEOUT_NS / `DSO_CLK_PERIOD_NS;
    // one-hot lock states
    localparam ST_HUNT = 3'b001;
    localparam ST_LOCKED = 3'b010;
    localparam ST_SLEEP = 3'b100;

    // ==========================================================
    // helpers
    function [3:0] wrap_inc;
        input [3:0] v;
        begin
            if (v == `DSO_FRAME_LAST) begin
                wrap_inc = 4'd0;
            end else begin
                wrap_inc = v + 4'd1;
            end
        end
    endfunction

    reg [2:0] state;
    reg [3:0] rx_pos;
    reg [WORD_W-1:0] rx_shift;
    reg [7:0] good_frames;
    reg [7:0] ref_idle;
    reg ref_prev;
    reg ref_ok;
    reg [WORD_W-1:0] buf_data [0:1];
    reg buf_wr;
    reg buf_rd;
    reg [1:0] buf_level;
    reg [3:0] out_pos;
    reg overflow;
    reg resync;
    reg [31:0] word_count;
    wire rx_bit;
    wire awake;
    wire locked;
    wire drive;
    wire frame_done;
    wire frame_good;
    wire push;
    wire pop;
    wire buf_full;
    wire buf_empty;
    wire load_slot;
    wire apb_access;
    wire wr_en;

    // ==========================================================
    // front end: differential sample and frame checks
    assign rx_bit = serial_in_positive & ~serial_in_negative;
    assign awake = sleep_request_n;
    assign locked = state == ST_LOCKED;
    assign drive = awake & output_enable & locked;
    assign frame_done = rx_pos == `DSO_STOP_POS;
    assign frame_good = frame_done & (rx_bit == `DSO_STOP_BIT);
    assign buf_full = buf_level == 2'd2;
    assign buf_empty = buf_level == 2'd0;
    assign push = frame_good & locked & ~buf_full;
    assign load_slot = recovered_clock_edge_select ?
        (out_pos == `DSO_HALF_FRAME) : (out_pos == 4'd0);
    assign pop = drive & out_ready & load_slot & ~buf_empty;

    // frame position: hunts for the start bit while not aligned
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rx_pos <= 4'd0;
            rx_shift <= {WORD_W{1'b0}};
        end else if (!awake) begin
            rx_pos <= 4'd0;
        end else if (rx_pos == `DSO_START_POS) begin
            if (rx_bit == `DSO_START_BIT) begin
                rx_pos <= `DSO_DATA_FIRST;
            end
        end else begin
            rx_pos <= wrap_inc(rx_pos);
            if (!frame_done) begin
                rx_shift <= {rx_shift[WORD_W-2:0], rx_bit};
            end
        end
    end

    // reference presence: missing edges drop lock
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ref_prev <= 1'b0;
            ref_idle <= 8'h00;
            ref_ok <= 1'b0;
        end else begin
            ref_prev <= pll_reference_clock;
            if (ref_prev != pll_reference_clock) begin
                ref_idle <= 8'h00;
                ref_ok <= 1'b1;
            end else if (ref_idle == REF_CYCLES[7:0]) begin
                ref_ok <= 1'b0;
            end else begin
                ref_idle <= ref_idle + 8'h01;
            end
        end
    end

    // lock state machine; a bad stop bit means lost alignment
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_HUNT;
            good_frames <= 8'h00;
        end else begin
            case (state)
                ST_HUNT: begin
                    if (!awake) begin
                        state <= ST_SLEEP;
                    end else if (!ref_ok || resync) begin
                        good_frames <= 8'h00;
                    end else if (frame_done && !frame_good) begin
                        good_frames <= 8'h00;
                    end else if (frame_good) begin
                        if (good_frames == LOCK_FRAMES - 8'd1) begin
                            state <= ST_LOCKED;
                            good_frames <= 8'h00;
                        end else begin
                            good_frames <= good_frames + 8'h01;
                        end
                    end
                end
                ST_LOCKED: begin
                    if (!awake) begin
                        state <= ST_SLEEP;
                    end else if (!ref_ok || resync ||
                                 (frame_done && !frame_good)) begin
                        state <= ST_HUNT;
                    end
                end
                ST_SLEEP: begin
                    good_frames <= 8'h00;
                    if (awake) begin
                        state <= ST_HUNT;
                    end
                end
                default: begin
                    state <= ST_HUNT;
                end
            endcase
        end
    end

    // ==========================================================
    // two-entry word buffer between decoder and output pins
    // the serial source cannot stall, so a full buffer drops
    // the word and raises the sticky overflow flag
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            buf_wr <= 1'b0;
            buf_rd <= 1'b0;
            buf_level <= 2'd0;
            buf_data[0] <= {WORD_W{1'b0}};
            buf_data[1] <= {WORD_W{1'b0}};
        end else if (!locked) begin
            buf_wr <= 1'b0;
            buf_rd <= 1'b0;
            buf_level <= 2'd0;
        end else begin
            if (push) begin
                buf_data[buf_wr] <= rx_shift;
                buf_wr <= ~buf_wr;
            end
            if (pop) begin
                buf_rd <= ~buf_rd;
            end
            if (push && !pop) begin
                buf_level <= buf_level + 2'd1;
            end else if (pop && !push) begin
                buf_level <= buf_level - 2'd1;
            end
        end
    end

    // ==========================================================
    // output phase: clock high for the first half of each word
    // idles at the last phase so the first high half is full length
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            out_pos <= `DSO_FRAME_LAST;
            recovered_clock <= 1'b0;
            parallel_word_out <= {WORD_W{1'b0}};
        end else if (!drive) begin
            out_pos <= `DSO_FRAME_LAST;
            recovered_clock <= 1'b0;
        end else if (out_ready) begin
            out_pos <= wrap_inc(out_pos);
            recovered_clock <= wrap_inc(out_pos) <
                `DSO_HALF_FRAME;
            if (pop) begin
                parallel_word_out <= buf_data[buf_rd];
            end
        end
    end

    // pin enables; lock floats only in sleep
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            parallel_word_oe_n <= 1'b1;
            recovered_clock_oe_n <= 1'b1;
            lock_n <= 1'b1;
            lock_oe_n <= 1'b1;
        end else begin
            parallel_word_oe_n <= ~drive;
            recovered_clock_oe_n <= ~drive;
            lock_n <= ~locked;
            lock_oe_n <= ~awake;
        end
    end

    // ==========================================================
    // apb slave: one wait state, error on unmapped address
    assign apb_access = psel & penable & ~pready;
    assign wr_en = apb_access & pwrite;

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            resync <= 1'b0;
            overflow <= 1'b0;
            word_count <= 32'h0000_0000;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access & (paddr != `DSO_REG_CTRL) &
                (paddr != `DSO_REG_STATUS) & (paddr != `DSO_REG_COUNT);
            if (push) begin
                word_count <= word_count + 32'h0000_0001;
            end
            // set wins over a write-one clear
            if (frame_good && locked && buf_full) begin
                overflow <= 1'b1;
            end else if (wr_en && paddr == `DSO_REG_STATUS &&
                         pwdata[`DSO_ST_OVERFLOW]) begin
                overflow <= 1'b0;
            end
            if (wr_en && paddr == `DSO_REG_CTRL) begin
                resync <= pwdata[`DSO_CTRL_RESYNC];
            end else begin
                resync <= 1'b0;                            // self clearing
            end
            prdata <= 32'h0000_0000;
            if (apb_access && !pwrite) begin
                case (paddr)
                    `DSO_REG_STATUS: begin
                        prdata[`DSO_ST_LOCKED] <= locked;
                        prdata[`DSO_ST_SLEEP] <= state == ST_SLEEP;
                        prdata[`DSO_ST_DRIVE] <= drive;
                        prdata[`DSO_ST_OVERFLOW] <= overflow;
                        prdata[`DSO_ST_LEVEL_HI:`DSO_ST_LEVEL_LO] <=
                            buf_level;
                    end
                    `DSO_REG_COUNT: begin
                        prdata <= word_count;
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
endmodule // dso_deserializer_out

// ---- bench/dso_ser_model.sv ----
// serializer model feeding the deserializer serial input
`timescale 1ns/1ps
module dso_ser_model (
    input wire clock,      // shared clock
    input wire sys_rst,    // async reset, high
    input wire send_en,    // frames back to back while high
    input wire bad_stop,   // corrupt every stop bit
    input wire [9:0] word, // word sent in each frame
    output logic ser_p,    // line, true side
    output logic ser_n     // line, inverted side
);
    logic [3:0] pos;
    logic [9:0] hold;
    logic bit_v;
    // ========
    // frame: start 1, ten bits msb first, stop 0
    always_comb begin
        if (pos == 4'h0) bit_v = 1'b1;
        else if (pos == 4'hb) bit_v = bad_stop;
        else bit_v = hold[4'ha - pos];
    end
    // idle line sends zeros, which only matter while hunting
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pos <= 4'h0;
            hold <= 10'h000;
            ser_p <= 1'b0;
            ser_n <= 1'b1;
        end else if (!send_en && pos == 4'h0) begin
            ser_p <= 1'b0;
            ser_n <= 1'b1;
        end else begin
            ser_p <= bit_v;
            ser_n <= ~bit_v;
            if (pos == 4'h0) hold <= word;
            pos <= (pos == 4'hb) ? 4'h0 : pos + 4'h1;
        end
    end
endmodule // dso_ser_model

// ---- bench/dso_out_props.sv ----
// assertions on the deserializer output block ports
`timescale 1ns/1ps
module dso_out_props #(
    parameter LOCK_FRAMES = 4,
    parameter WORD_W = 10
) (
    input wire clock,                       // clock
    input wire sys_rst,                     // reset
    input wire recovered_clock_edge_select, // strobe edge
    input wire sleep_request_n,             // powerdown
    input wire output_enable,               // enable
    input wire [WORD_W-1:0] parallel_word_out, // word
    input wire parallel_word_oe_n,          // word float
    input wire recovered_clock,             // clock out
    input wire recovered_clock_oe_n,        // clock float
    input wire lock_n,                      // lock
    input wire lock_oe_n,                   // lock float
    input wire psel,                        // apb select
    input wire penable,                     // apb enable
    input wire pready                       // apb ready
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ========
    // drive and float; margins cover the state and pin flops
    float_unlocked_a: assert property (
        lock_n && $past(lock_n) |-> parallel_word_oe_n && recovered_clock_oe_n)
        else $error("word or clock driven while unlocked");
    sleep_float_a: assert property (
        (!sleep_request_n) [*4] |->
        parallel_word_oe_n && recovered_clock_oe_n && lock_oe_n)
        else $error("output driven while asleep");
    lock_drive_a: assert property (
        sleep_request_n [*4] |-> !lock_oe_n)
        else $error("lock not driven while awake");
    enable_float_a: assert property (
        (!output_enable) [*4] |-> parallel_word_oe_n && recovered_clock_oe_n)
        else $error("word or clock driven while disabled");
    // ========
    // recovered clock shape, twelve cycles a period
    clock_idle_a: assert property (
        lock_n [*4] |-> !recovered_clock)
        else $error("recovered clock runs while unlocked");
    clock_high_a: assert property (
        $rose(recovered_clock) |->
        (recovered_clock [*6]) or (##[1:6] recovered_clock_oe_n))
        else $error("recovered clock high phase too short");
    clock_low_a: assert property (
        $fell(recovered_clock) |->
        ((!recovered_clock) [*6]) or (##[0:5] recovered_clock_oe_n))
        else $error("recovered clock low phase too short");
    // ========
    // word moves in the opposite clock half, five cycles before the strobe edge
    word_fall_a: assert property (
        $changed(parallel_word_out) && !parallel_word_oe_n &&
        !$past(parallel_word_oe_n) && recovered_clock_edge_select &&
        $stable(recovered_clock_edge_select) |-> !recovered_clock)
        else $error("word changed near rising strobe");
    word_rise_a: assert property (
        $changed(parallel_word_out) && !parallel_word_oe_n &&
        !$past(parallel_word_oe_n) && !recovered_clock_edge_select &&
        $stable(recovered_clock_edge_select) |-> recovered_clock)
        else $error("word changed near falling strobe");
    apb_wait_a: assert property (
        psel && penable && !pready |=> pready)
        else $error("apb answer late");
    lock_c: cover property ($fell(lock_n));
    sleep_c: cover property ((!sleep_request_n) [*4]);
    word_c: cover property ($changed(parallel_word_out));
endmodule // dso_out_props
bind dso_deserializer_out dso_out_props #(.LOCK_FRAMES(LOCK_FRAMES),
    .WORD_W(WORD_W)) dso_out_props_i (.clock(clock), .sys_rst(sys_rst),
    .recovered_clock_edge_select(recovered_clock_edge_select),
    .sleep_request_n(sleep_request_n), .output_enable(output_enable),
    .parallel_word_out(parallel_word_out),
    .parallel_word_oe_n(parallel_word_oe_n),
    .recovered_clock(recovered_clock),
    .recovered_clock_oe_n(recovered_clock_oe_n), .lock_n(lock_n),
    .lock_oe_n(lock_oe_n), .psel(psel), .penable(penable), .pready(pready));

// ---- bench/tb_top.sv ----
// testbench for the deserializer output and lock block
`timescale 1ns/1ps
module tb_top;
    logic clock = 0, sys_rst = 1, ref_clk = 0, sel = 1, sleep_n = 1;
    logic out_en = 1, rdy = 1, psel = 0, penable = 0, pwrite = 0;
    logic send = 0, bad = 0, sp, sn, pw_oe_n, rc, rc_oe_n, lk_n, lk_oe_n;
    logic pready, pslverr, er;
    logic [3:0] paddr = 4'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, cnt;
    logic [9:0] word = 10'h2a5, pw;
    int n_errors = 0, tests_run = 0, cyc = 0;
    dso_ser_model dso_ser_model_i (.clock(clock), .sys_rst(sys_rst),
        .send_en(send), .bad_stop(bad), .word(word), .ser_p(sp), .ser_n(sn));
    dso_deserializer_out #(.LOCK_FRAMES(2)) dso_deserializer_out_i (
        .clock(clock), .sys_rst(sys_rst), .serial_in_positive(sp),
        .serial_in_negative(sn), .pll_reference_clock(ref_clk),
        .recovered_clock_edge_select(sel), .sleep_request_n(sleep_n),
        .output_enable(out_en), .out_ready(rdy), .parallel_word_out(pw),
        .parallel_word_oe_n(pw_oe_n), .recovered_clock(rc),
        .recovered_clock_oe_n(rc_oe_n), .lock_n(lk_n), .lock_oe_n(lk_oe_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    initial forever #5 clock = ~clock;
    // ========
    // reference toggles every 8 cycles; timeout ends a hang
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc % 8 == 0) ref_clk <= ~ref_clk;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end
    task test_done;
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    // apb master: setup, access, hold until pready
    // only the cycle timeout ends a wait for pready
    task apb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wait_lock(input logic v);
        for (int n = 0; n < 300 && lk_n !== v; n++) @(posedge clock);
        repeat (4) @(posedge clock);
        check(lk_n, v);
    endtask
    task t_edges;
        for (int s = 0; s < 2; s++) begin
            sel <= s[0];
            word <= s[0] ? 10'h35a : 10'h0c3;
            repeat (60) @(posedge clock);
            if (s[0]) @(posedge rc);
            else @(negedge rc);
            check(pw, word);
        end
        $display("edge select done");
    endtask
    task t_modes;
        out_en <= 0;
        repeat (4) @(posedge clock);
        check({pw_oe_n, rc_oe_n, lk_oe_n, lk_n}, 4'hc);
        out_en <= 1;
        repeat (4) @(posedge clock);
        check({pw_oe_n, rc_oe_n, lk_oe_n, lk_n}, 4'h0);
        sleep_n <= 0;
        send <= 0;
        repeat (4) @(posedge clock);
        check({pw_oe_n, rc_oe_n, lk_oe_n}, 3'h7);
        // idle line on waking, so the hunt meets a true start bit
        repeat (12) @(posedge clock);
        sleep_n <= 1;
        send <= 1;
        wait_lock(0);
        bad <= 1;
        wait_lock(1);
        check({pw_oe_n, rc_oe_n}, 2'h3);
        bad <= 0;
        wait_lock(0);
        $display("drive modes done");
    endtask
    task t_regs;
        apb(0, 4'h4, 0);
        check({rd[2:0], er}, 4'ha);
        // one word per frame is buffered while flowing
        apb(0, 4'h8, 0);
        cnt = rd;
        repeat (20) @(posedge clock);
        apb(0, 4'h8, 0);
        check(rd - cnt, 32'h2);
        apb(1, 4'h4, 32'h8);
        rdy <= 0;
        repeat (60) @(posedge clock);
        apb(0, 4'h4, 0);
        check(rd[5:3], 3'h5);
        rdy <= 1;
        @(posedge rc);
        check(pw, word);
        apb(0, 4'hc, 0);
        check(rd, 32'h0);
        check(er, 32'h1);
        apb(1, 4'h0, 32'h1);
        wait_lock(1);
        $display("registers done");
    endtask
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 0;
        @(posedge clock);
        check({pw_oe_n, rc_oe_n, lk_n}, 3'h7);
        send <= 1;
        wait_lock(0);
        t_edges();
        t_modes();
        t_regs();
        test_done();
    end
endmodule // tb_top
